// file: core/hpi_pkg.sv
package port_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HW_W   = 16;                  // Host halfword width
  localparam int WORD_W = 32;                  // Internal word width
  localparam int SEL_W  = 2;                   // Access select width

  // ----------------------------------------------------------------
  // Access select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL      = 2'h0;  // Control register
  localparam logic [1:0] SEL_DATA_AUTO = 2'h1;  // Data, autoincrement
  localparam logic [1:0] SEL_ADDR      = 2'h2;  // Address register
  localparam logic [1:0] SEL_DATA      = 2'h3;  // Data, fixed address

  // ----------------------------------------------------------------
  // Reset values and steps
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [31:0] ADDR_STEP  = 32'h00000004;  // One word per advance

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int STROBE_LOW_NS   = 40;         // Two CPU periods
  localparam int STROBE_HIGH_NS  = 40;         // Two CPU periods
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC      = 6;          // Covers both synchronisers
  localparam int CNT_W           = 4;

endpackage : port_pkg

// file: core/host_port_if.sv
`timescale 1ns/1ps
interface host_port_if;
  import port_pkg::*;

  logic              host_chip_select_n;   // Chip select, active low
  logic              host_data_strobe_a;   // Data strobe A
  logic              host_data_strobe_b;   // Data strobe B
  logic              host_addr_strobe_n;   // Optional address strobe
  logic [SEL_W-1:0]  access_register_select;
  logic              host_direction;       // 1 = read, 0 = write
  logic              halfword_select;      // 0 first, 1 second halfword
  logic [HW_W-1:0]   host_hd_out;          // Host drive value
  logic              host_hd_oe_n;         // Host drives bus when low
  logic [HW_W-1:0]   dev_hd_out;           // Device drive value
  logic              dev_hd_oe_n;          // Device drives bus when low
  logic              host_ready_n;         // Device busy when high
  wire  [HW_W-1:0]   host_halfword_bus;    // Resolved bus level

  // ----------------------------------------------------------------
  // Bus resolution
  // ----------------------------------------------------------------
  // Device wins if both enable; idle bus reads as zero
  assign host_halfword_bus = !dev_hd_oe_n  ? dev_hd_out :
                             !host_hd_oe_n ? host_hd_out : 16'h0000;

  modport device (
    input  host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    input  host_addr_strobe_n, access_register_select, host_direction,
    input  halfword_select, host_halfword_bus,
    output dev_hd_out, dev_hd_oe_n, host_ready_n
  );

  modport host (
    output host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    output host_addr_strobe_n, access_register_select, host_direction,
    output halfword_select, host_hd_out, host_hd_oe_n,
    input  host_halfword_bus, host_ready_n
  );

endinterface : host_port_if

// file: core/host_port_device.sv
`timescale 1ns/1ps
// Function
// - Strobe is XNOR of data strobes, OR select
// - Selects qualify access, taken at strobe fall
// - Host lowers address strobe around strobe fall
// - Strobe low at least two clock periods
// - Strobe high two periods between accesses
// - Write data captured at strobe rise
// - Host holds strobe until ready low
// - Ready low whenever chip select high
// - Busy shown at select fall if pending
// - Data read fetches word at first fall unless a prefetched word serves an autoincrement read
// - Busy after second halfword data write/autoread
// - Other accesses leave ready untouched
// - Drive read data one clock before ready
module host_port_device
  import port_pkg::*;
(
  input  wire logic              CLK,        // CPU clock
  input  wire logic              RST_N,      // Sync reset, active low
  host_port_if.device            link,       // Host pins
  output logic                   DMA_REQ,    // Auxiliary channel request
  output logic                   DMA_WRITE,  // 1 write, 0 read
  output logic [WORD_W-1:0]      DMA_ADDR,   // Byte address of the word
  output logic [WORD_W-1:0]      DMA_WDATA,  // Write word
  input  wire logic              DMA_ACK,    // One-cycle completion
  input  wire logic [WORD_W-1:0] DMA_RDATA,  // Read word, valid with ack
  output logic [HW_W-1:0]        CTRL_WORD   // Control register contents
);

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_FETCH    = 5'b00010,
    ST_SHOW     = 5'b00100,
    ST_WRITE    = 5'b01000,
    ST_PREFETCH = 5'b10000
  } dev_state_t;

  localparam int PIN_W = HW_W + 7;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             cs_n_s;
  logic             ds_a_s;
  logic             ds_b_s;
  logic [1:0]       sel_s;
  logic             dir_s;
  logic             hw_s;
  logic [HW_W-1:0]  hd_s;

  assign pin_raw = {link.host_chip_select_n, link.host_data_strobe_a,
                    link.host_data_strobe_b, link.access_register_select,
                    link.host_direction, link.halfword_select, link.host_halfword_bus};
  assign {cs_n_s, ds_a_s, ds_b_s, sel_s, dir_s, hw_s, hd_s} = pin_sync;

  // All host pins but the address strobe are asynchronous to CLK, so two stages each
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_meta <= {PIN_W{1'b1}};
      pin_sync <= {PIN_W{1'b1}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Combined strobe and its edges
  // ----------------------------------------------------------------
  logic strobe_n;
  logic strobe_d;
  logic strobe_fall;
  logic strobe_rise;

  assign strobe_n    = ~(ds_a_s ^ ds_b_s) | cs_n_s;
  assign strobe_fall = strobe_d & ~strobe_n;
  assign strobe_rise = ~strobe_d & strobe_n;

  // Previous strobe level for edge detection
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      strobe_d <= 1'b1;
    end else begin
      strobe_d <= strobe_n;
    end
  end

  // ----------------------------------------------------------------
  // Access qualifiers latched at the falling strobe
  // ----------------------------------------------------------------
  logic [1:0] acc_sel;
  logic       acc_dir;
  logic       acc_hw;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      acc_sel <= SEL_CTRL;
      acc_dir <= 1'b1;
      acc_hw  <= 1'b0;
    end else if (strobe_fall) begin
      acc_sel <= sel_s;
      acc_dir <= dir_s;
      acc_hw  <= hw_s;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic dev_state_idle;
  logic sel_s_data;
  logic acc_data;
  logic acc_auto;
  logic start_fetch;
  logic start_write;
  logic start_advance;
  logic host_wr;
  logic prefetched;

  assign sel_s_data = (sel_s == SEL_DATA) | (sel_s == SEL_DATA_AUTO);
  assign acc_data   = (acc_sel == SEL_DATA) | (acc_sel == SEL_DATA_AUTO);
  assign acc_auto   = (acc_sel == SEL_DATA_AUTO);
  assign host_wr    = strobe_rise & ~acc_dir;
  // A prefetched word serves the next autoincrement read directly
  assign start_fetch = strobe_fall & dir_s & ~hw_s & sel_s_data
                       & ~(prefetched & (sel_s == SEL_DATA_AUTO));
  assign start_write   = host_wr & acc_hw & acc_data;
  assign start_advance = strobe_rise & acc_dir & acc_hw & acc_auto;

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  dev_state_t state;
  dev_state_t next_state;

  // New access events are ignored while busy; host waits on ready
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_fetch) begin
          next_state = ST_FETCH;
        end else if (start_write) begin
          next_state = ST_WRITE;
        end else if (start_advance) begin
          next_state = ST_PREFETCH;
        end
      end
      ST_FETCH:    next_state = DMA_ACK ? ST_SHOW : ST_FETCH;
      ST_SHOW:     next_state = ST_IDLE;
      ST_WRITE:    next_state = DMA_ACK ? ST_IDLE : ST_WRITE;
      ST_PREFETCH: next_state = DMA_ACK ? ST_IDLE : ST_PREFETCH;
    endcase
  end

  assign dev_state_idle = (state == ST_IDLE);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary channel request
  // ----------------------------------------------------------------
  logic next_req;

  assign next_req = (next_state == ST_FETCH) | (next_state == ST_WRITE)
                    | (next_state == ST_PREFETCH);

  // Request is a level held until the acknowledge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DMA_REQ   <= 1'b0;
      DMA_WRITE <= 1'b0;
    end else begin
      DMA_REQ   <= next_req;
      DMA_WRITE <= (next_state == ST_WRITE);
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] addr_reg;
  logic [WORD_W-1:0] data_reg;
  logic [HW_W-1:0]   ctrl_reg;
  logic              addr_wr;
  logic              data_wr;
  logic              word_loaded;

  assign addr_wr     = host_wr & (acc_sel == SEL_ADDR);
  assign data_wr     = host_wr & acc_data;
  assign word_loaded = DMA_ACK & ((state == ST_FETCH) | (state == ST_PREFETCH));

  // Address: host halves, advance on autoincrement completion
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      addr_reg <= ADDR_RESET;
    end else if (addr_wr) begin
      addr_reg[acc_hw*HW_W +: HW_W] <= hd_s;
    end else if (start_advance & dev_state_idle) begin
      addr_reg <= addr_reg + ADDR_STEP;
    end else if ((state == ST_WRITE) & DMA_ACK & acc_auto) begin
      addr_reg <= addr_reg + ADDR_STEP;
    end
  end

  // Data: host halves or a word loaded by the channel
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      data_reg <= DATA_RESET;
    end else if (word_loaded) begin
      data_reg <= DMA_RDATA;
    end else if (data_wr) begin
      data_reg[acc_hw*HW_W +: HW_W] <= hd_s;
    end
  end

  // Control register has no side effects on ready
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET;
    end else if (host_wr & (acc_sel == SEL_CTRL)) begin
      ctrl_reg <= hd_s;
    end
  end

  // Prefetch validity; any address or data write makes it stale
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      prefetched <= 1'b0;
    end else if ((state == ST_PREFETCH) & DMA_ACK) begin
      prefetched <= 1'b1;
    end else if (addr_wr | data_wr | start_fetch | (strobe_fall & sel_s_data & ~dir_s)) begin
      prefetched <= 1'b0;
    end
  end

  assign DMA_ADDR  = addr_reg;
  assign DMA_WDATA = data_reg;
  assign CTRL_WORD = ctrl_reg;

  // ----------------------------------------------------------------
  // Read path and ready
  // ----------------------------------------------------------------
  logic [HW_W-1:0] read_mux;
  logic            next_ready_n;
  logic            next_oe_n;

  assign read_mux = (sel_s == SEL_CTRL) ? ctrl_reg :
                    (sel_s == SEL_ADDR) ? addr_reg[hw_s*HW_W +: HW_W] :
                                          data_reg[hw_s*HW_W +: HW_W];
  // Busy through the show cycle so data leads ready by one clock
  assign next_ready_n = ~cs_n_s & (~(next_state == ST_IDLE) | (state == ST_SHOW));
  assign next_oe_n    = ~(~strobe_n & dir_s);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      link.host_ready_n <= 1'b0;
      link.dev_hd_oe_n  <= 1'b1;
      link.dev_hd_out   <= 16'h0000;
    end else begin
      link.host_ready_n <= next_ready_n;
      link.dev_hd_oe_n  <= next_oe_n;
      link.dev_hd_out   <= read_mux;
    end
  end

endmodule : host_port_device

// file: core/host_port_master.sv
`timescale 1ns/1ps
module host_port_master
  import port_pkg::*;
(
  input  wire logic              CLK,        // CPU clock
  input  wire logic              RST_N,      // Sync reset, active low
  host_port_if.host              link,       // Device pins
  input  wire logic              CMD_VALID,  // Start a word access
  input  wire logic [SEL_W-1:0]  CMD_SEL,    // Register to access
  input  wire logic              CMD_READ,   // 1 read, 0 write
  input  wire logic [WORD_W-1:0] CMD_WDATA,  // Write word
  output logic                   CMD_READY,  // Idle, command accepted
  output logic                   RSP_VALID,  // One-cycle completion
  output logic [WORD_W-1:0]      RSP_RDATA   // Read word
);

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_LOW   = 4'b0100,
    H_HIGH  = 4'b1000
  } host_state_t;

  // ----------------------------------------------------------------
  // Synchronisers for device outputs
  // ----------------------------------------------------------------
  logic [HW_W:0] in_meta;
  logic [HW_W:0] in_sync;
  logic          ready_n_s;
  logic [HW_W-1:0] hd_s;

  assign {ready_n_s, hd_s} = in_sync;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      in_meta <= {1'b1, 16'h0000};
      in_sync <= {1'b1, 16'h0000};
    end else begin
      in_meta <= {link.host_ready_n, link.host_halfword_bus};
      in_sync <= in_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  host_state_t       state;
  logic [CNT_W-1:0]  cnt;
  logic [WORD_W-1:0] wdata;
  logic              low_done;
  logic              high_done;

  // Settle covers the device seeing the strobe and ready returning
  assign low_done  = (cnt >= CNT_W'(SETTLE_CYC)) & (cnt >= CNT_W'(STROBE_LOW_CYC))
                     & ~ready_n_s;
  assign high_done = (cnt >= CNT_W'(STROBE_HIGH_CYC - 1));

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state                       <= H_IDLE;
      cnt                         <= '0;
      wdata                       <= 32'h00000000;
      CMD_READY                   <= 1'b0;
      RSP_VALID                   <= 1'b0;
      RSP_RDATA                   <= 32'h00000000;
      link.host_chip_select_n     <= 1'b1;
      link.host_data_strobe_a     <= 1'b1;
      link.host_data_strobe_b     <= 1'b1;
      link.host_addr_strobe_n     <= 1'b1;
      link.access_register_select <= SEL_CTRL;
      link.host_direction         <= 1'b1;
      link.halfword_select        <= 1'b0;
      link.host_hd_out            <= 16'h0000;
      link.host_hd_oe_n           <= 1'b1;
    end else begin
      RSP_VALID <= 1'b0;
      cnt       <= cnt + 1'b1;
      unique case (state)
        H_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID & CMD_READY) begin
            // Selects and address strobe lead the strobe
            CMD_READY                   <= 1'b0;
            cnt                         <= '0;
            wdata                       <= CMD_WDATA;
            link.host_chip_select_n     <= 1'b0;
            link.host_addr_strobe_n     <= 1'b0;
            link.access_register_select <= CMD_SEL;
            link.host_direction         <= CMD_READ;
            link.halfword_select        <= 1'b0;
            link.host_hd_out            <= CMD_WDATA[15:0];
            link.host_hd_oe_n           <= CMD_READ;
            state                       <= H_SETUP;
          end
        end
        H_SETUP: begin
          // Device drops strobes seen while busy, so wait out a busy flag
          if ((cnt >= CNT_W'(SETTLE_CYC)) & ~ready_n_s) begin
            link.host_data_strobe_a <= 1'b0;
            cnt                     <= '0;
            state                   <= H_LOW;
          end
        end
        H_LOW: begin
          link.host_addr_strobe_n <= 1'b1;
          if (low_done) begin
            if (link.host_direction) begin
              RSP_RDATA[link.halfword_select*HW_W +: HW_W] <= hd_s;
            end
            link.host_data_strobe_a <= 1'b1;
            cnt                     <= '0;
            state                   <= H_HIGH;
          end
        end
        H_HIGH: begin
          link.host_hd_oe_n <= 1'b1;  // Data held one cycle past rise
          if (high_done) begin
            if (!link.halfword_select) begin
              link.halfword_select    <= 1'b1;
              link.host_addr_strobe_n <= 1'b0;
              link.host_hd_out        <= wdata[31:16];
              link.host_hd_oe_n       <= link.host_direction;
              state                   <= H_SETUP;
            end else begin
              link.host_chip_select_n <= 1'b1;
              RSP_VALID               <= 1'b1;
              state                   <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule : host_port_master

// file: testbench/host_port_asserts.sv
`timescale 1ns/1ps
module host_port_asserts
  import port_pkg::*;
(
  input wire logic             CLK,                    // CPU clock
  input wire logic             RST_N,                  // Sync reset
  input wire logic             host_chip_select_n,     // Select
  input wire logic             host_data_strobe_a,     // Strobe A
  input wire logic             host_data_strobe_b,     // Strobe B
  input wire logic             host_addr_strobe_n,     // Address strobe
  input wire logic [SEL_W-1:0] access_register_select, // Register
  input wire logic             host_direction,         // 1 read
  input wire logic             halfword_select,        // Half
  input wire logic [HW_W-1:0]  host_hd_out,            // Host value
  input wire logic             host_hd_oe_n,           // Host enable
  input wire logic [HW_W-1:0]  dev_hd_out,             // Device value
  input wire logic             dev_hd_oe_n,            // Device enable
  input wire logic             host_ready_n            // Busy when high
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Combined strobe and qualifiers rebuilt from the pins
  wire             stb = ~(host_data_strobe_a ^ host_data_strobe_b) | host_chip_select_n;
  wire [SEL_W+1:0] sel = {access_register_select, host_direction, halfword_select};

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // One spare cycle over the sync chain, to allow for the pin flops
  property p_ready_idle;
    host_chip_select_n [*5] |-> !host_ready_n;
  endproperty
  property p_stb_low;
    $fell(stb) |=> !stb;
  endproperty
  property p_stb_high;
    $rose(stb) |=> stb;
  endproperty
  property p_hold_ready;
    $rose(stb) |-> !$past(host_ready_n);
  endproperty
  property p_as_setup;
    $fell(stb) |-> !host_addr_strobe_n && !$past(host_addr_strobe_n);
  endproperty
  property p_sel_hold;
    $fell(stb) |-> $stable(sel) ##1 $stable(sel);
  endproperty
  property p_wdata_hold;
    $rose(stb) && !host_direction |-> !host_hd_oe_n && $stable(host_hd_out);
  endproperty
  // Device may only open the bus for a read, after the strobe settled
  property p_oe_read;
    $fell(dev_hd_oe_n) |-> host_direction && !stb && !$past(stb, 2);
  endproperty
  property p_data_lead;
    $fell(host_ready_n) && !dev_hd_oe_n |-> $stable(dev_hd_out);
  endproperty

  a_ready_idle: assert property (p_ready_idle)
    else $error("ready high while deselected");
  a_stb_low: assert property (p_stb_low)
    else $error("strobe low too short");
  a_stb_high: assert property (p_stb_high)
    else $error("strobe high too short");
  a_hold_ready: assert property (p_hold_ready)
    else $error("strobe released while busy");
  a_as_setup: assert property (p_as_setup)
    else $error("address strobe not low around strobe fall");
  a_sel_hold: assert property (p_sel_hold)
    else $error("selects moved at strobe fall");
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write data moved at strobe rise");
  a_oe_read: assert property (p_oe_read)
    else $error("device drove bus outside a read strobe");
  a_data_lead: assert property (p_data_lead)
    else $error("read data changed as ready fell");

  c_busy: cover property ($rose(host_ready_n));
  c_read: cover property (!dev_hd_oe_n ##1 dev_hd_oe_n);
  c_wr2: cover property ($rose(stb) && !host_direction && halfword_select);
endmodule : host_port_asserts

// file: testbench/host_port_handshake_test.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module host_port_handshake_test;
  import port_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cmd_valid = 1'b0;
  logic [SEL_W-1:0]  cmd_sel = SEL_CTRL;
  logic              cmd_read = 1'b0;
  logic [WORD_W-1:0] cmd_wdata = '0;
  logic              cmd_ready, rsp_valid, dma_req, dma_write;
  logic [WORD_W-1:0] rsp_rdata, dma_addr, dma_wdata, rd;
  logic              dma_ack = 1'b0;
  logic [WORD_W-1:0] dma_rdata = '0;
  logic [HW_W-1:0]   ctrl_word;
  logic [WORD_W-1:0] mem [16];
  int                dma_delay = 1;
  int                n_dma = 0;
  int                n0;
  logic              busy_seen = 1'b0;
  int                n_errors = 0;
  int                total_checks = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // ----------------------------------------------------------------
  // Both ends joined across the interface
  // ----------------------------------------------------------------
  host_port_if host_port_if_inst ();
  host_port_device host_port_device_inst (.CLK(clk), .RST_N(rst_n),
    .link(host_port_if_inst.device), .DMA_REQ(dma_req), .DMA_WRITE(dma_write),
    .DMA_ADDR(dma_addr), .DMA_WDATA(dma_wdata), .DMA_ACK(dma_ack),
    .DMA_RDATA(dma_rdata), .CTRL_WORD(ctrl_word));
  host_port_master host_port_master_inst (.CLK(clk), .RST_N(rst_n),
    .link(host_port_if_inst.host), .CMD_VALID(cmd_valid), .CMD_SEL(cmd_sel),
    .CMD_READ(cmd_read), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
  host_port_asserts host_port_asserts_inst (.CLK(clk), .RST_N(rst_n),
    .host_chip_select_n(host_port_if_inst.host_chip_select_n),
    .host_data_strobe_a(host_port_if_inst.host_data_strobe_a),
    .host_data_strobe_b(host_port_if_inst.host_data_strobe_b),
    .host_addr_strobe_n(host_port_if_inst.host_addr_strobe_n),
    .access_register_select(host_port_if_inst.access_register_select),
    .host_direction(host_port_if_inst.host_direction),
    .halfword_select(host_port_if_inst.halfword_select),
    .host_hd_out(host_port_if_inst.host_hd_out),
    .host_hd_oe_n(host_port_if_inst.host_hd_oe_n),
    .dev_hd_out(host_port_if_inst.dev_hd_out),
    .dev_hd_oe_n(host_port_if_inst.dev_hd_oe_n),
    .host_ready_n(host_port_if_inst.host_ready_n));

  // Busy flag seen by the host at any point of a test
  always @(negedge clk) begin
    if (host_port_if_inst.host_ready_n === 1'b1) busy_seen = 1'b1;
  end

  // Memory behind the auxiliary channel; data is scrambled outside ack
  initial begin
    forever begin
      @(negedge clk);
      if (dma_req === 1'b1) begin
        n_dma++;
        repeat (dma_delay) @(negedge clk);
        if (dma_write === 1'b1) mem[dma_addr[5:2]] = dma_wdata;
        dma_rdata = mem[dma_addr[5:2]];
        dma_ack = 1'b1;
        @(negedge clk);
        dma_ack = 1'b0;
        dma_rdata = ~dma_rdata;
        @(negedge clk);
      end
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // One whole word through the host end; entered at a falling edge
  task automatic word_op(input logic [1:0] sel, input logic rdn,
                         input logic [31:0] wd, output logic [31:0] rdata);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    cmd_sel = sel;
    cmd_read = rdn;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      n_errors++;
      $display("CHECK FAILED word_op expected done seen timeout");
      report_and_stop();
    end
    rdata = rsp_rdata;
  endtask : word_op

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'h5A000000 + i;
    repeat (16) @(negedge clk);
    `CHK("ready_n", 1'b0, host_port_if_inst.host_ready_n)
    `CHK("dev_oe_n", 1'b1, host_port_if_inst.dev_hd_oe_n)
    rst_n = 1'b1;
    @(negedge clk);
    // Control and address never touch ready and never reach memory
    busy_seen = 1'b0;
    n0 = n_dma;
    word_op(SEL_CTRL, 1'b0, 32'hA5C3A5C3, rd);
    word_op(SEL_CTRL, 1'b1, 32'h00000000, rd);
    `CHK("ctrl", 16'hA5C3, ctrl_word)
    `CHK("ctrl rd", 16'hA5C3, rd[15:0])
    word_op(SEL_ADDR, 1'b0, 32'h00000010, rd);
    word_op(SEL_ADDR, 1'b1, 32'h00000000, rd);
    `CHK("addr rd", 32'h00000010, rd)
    `CHK("dma addr", 32'h00000010, dma_addr)
    `CHK("no dma", n0, n_dma)
    `CHK("no busy", 1'b0, busy_seen)
    $display("test ctrl_addr done");
    // Fixed data write then read, slow memory keeps the port busy
    dma_delay = 20;
    word_op(SEL_DATA, 1'b0, 32'h12345678, rd);
    word_op(SEL_DATA, 1'b1, 32'h00000000, rd);
    `CHK("fixed rd", 32'h12345678, rd)
    `CHK("mem4", 32'h12345678, mem[4])
    `CHK("two dma", n0 + 2, n_dma)
    `CHK("busy", 1'b1, busy_seen)
    $display("test fixed_data done");
    // Autoincrement reads with a quick memory
    dma_delay = 1;
    word_op(SEL_ADDR, 1'b0, 32'h00000020, rd);
    for (int i = 0; i < 2; i++) begin
      word_op(SEL_DATA_AUTO, 1'b1, 32'h00000000, rd);
      `CHK("auto rd", 32'h5A000008 + i, rd)
    end
    word_op(SEL_ADDR, 1'b1, 32'h00000000, rd);
    `CHK("auto addr", 32'h00000028, rd)
    $display("test auto_read done");
    // Back to back autoincrement writes while the memory lags
    dma_delay = 12;
    busy_seen = 1'b0;
    word_op(SEL_ADDR, 1'b0, 32'h00000030, rd);
    word_op(SEL_DATA_AUTO, 1'b0, 32'h11112222, rd);
    word_op(SEL_DATA_AUTO, 1'b0, 32'h33334444, rd);
    word_op(SEL_ADDR, 1'b1, 32'h00000000, rd);
    `CHK("wr addr", 32'h00000038, rd)
    `CHK("mem12", 32'h11112222, mem[12])
    `CHK("mem13", 32'h33334444, mem[13])
    `CHK("busy wr", 1'b1, busy_seen)
    $display("test auto_write done");
    report_and_stop();
  end
endmodule : host_port_handshake_test
